/* inc/spread_cfg_pkg.sv */
// Constants and register layout of the spread spectrum modem configuration.
package spread_cfg_pkg;

  // ***************************************************************
  // Register byte addresses
  // ***************************************************************
  localparam logic [7:0] ADDR_OPMODE = 8'h00;
  localparam logic [7:0] ADDR_SETUP_ONE = 8'h04;
  localparam logic [7:0] ADDR_SETUP_TWO = 8'h08;
  localparam logic [7:0] ADDR_DETECT_TUNE = 8'h0C;
  localparam logic [7:0] ADDR_DETECT_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int MODE_SEL_BIT = 7;
  localparam int HDRLESS_BIT = 0;
  localparam int FEC_LSB = 1;
  localparam int BW_LSB = 4;
  localparam int EXP_LSB = 4;
  localparam int STAT_COUNT_LSB = 8;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_EMPTY_BIT = 0;

  // ***************************************************************
  // Operating modes, field limits, reset values and FEC overhead base
  // ***************************************************************
  localparam logic [2:0] OPMODE_SLEEP = 3'h0;
  localparam logic [2:0] OPMODE_RESET = 3'h1;
  localparam logic [3:0] EXP_MIN = 4'h6;
  localparam logic [3:0] EXP_MAX = 4'hC;
  localparam logic [3:0] EXP_RESET = 4'h7;
  localparam logic [2:0] FEC_MIN = 3'h1;
  localparam logic [2:0] FEC_MAX = 3'h4;
  localparam logic [2:0] FEC_RESET = 3'h1;
  localparam logic [3:0] BW_MAX = 4'h9;
  localparam logic [3:0] BW_RESET = 4'h7;
  localparam logic [2:0] TUNE_RESET = 3'h3;
  localparam logic [7:0] LEVEL_RESET = 8'h0A;
  localparam logic [7:0] FSK_BW_RESET = 8'h15;
  localparam logic [2:0] FEC_BASE_QUARTERS = 3'h4;

  // Double sideband bandwidth in Hz for each bandwidth code.
  localparam int BW_W = 19;
  function automatic logic [BW_W-1:0] bw_hz(input logic [3:0] code);
    logic [BW_W-1:0] r;
    r = 19'h00000;
    case (code)
      4'h0: r = 19'd7800;
      4'h1: r = 19'd10400;
      4'h2: r = 19'd15600;
      4'h3: r = 19'd20800;
      4'h4: r = 19'd31200;
      4'h5: r = 19'd41700;
      4'h6: r = 19'd62500;
      4'h7: r = 19'd125000;
      4'h8: r = 19'd250000;
      4'h9: r = 19'd500000;
      default: r = 19'h00000;
    endcase
    return r;
  endfunction

endpackage

/* inc/buf_port_if.sv */
// Port bundle between the configuration block and its data buffer memory.
`timescale 1ns/1ps
`default_nettype none
interface buf_port_if #(parameter int AW = 6, parameter int DW = 8);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* design/buf_mem.sv */
// Dual-port data buffer memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module buf_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic ce,
  buf_port_if.mem port
);

  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] rd_data_reg;

  // Storage has no reset; contents are undefined until written.
  always_ff @(posedge pclk)
  begin
    if (ce)
    begin
      if (port.wr_en)
      begin
        store[port.wr_addr] <= port.wr_data;
      end
      rd_data_reg <= store[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_reg;

endmodule
`default_nettype wire

/* design/spread_modem_param_config.sv */
// APB register file and parameter decode of the spread spectrum modem.
//
// Overview of operation
// RULE1 - Host changes modem selection only in Sleep; other writes are ignored.
// RULE2 - Modem owns a dual-port data FIFO reached through the register port.
// RULE3 - Selecting spread mode swaps in a different configuration register map.
// RULE4 - Chip exponent 6..12 gives two to that power chips per symbol.
// RULE5 - Both link ends must use the same chip exponent.
// RULE6 - With exponent six the host must select headerless operation.
// RULE7 - With exponent six the host sets detect tuning to binary 101.
// RULE8 - With exponent six the host writes 0C to detect level.
// RULE9 - Host restores detect defaults for any other exponent.
// RULE10 - FEC ratio 1..4 selects 4/5..4/8, overhead 1.25..2; the 3-bit overhead_quarters wraps to 0 for ratio 4.
// RULE11 - FEC ratio travels in the header unless headerless mode is on.
// RULE12 - Bandwidth is one of ten settings from 7.8 to 500 kHz.
// RULE13 - Bandwidth means total double sideband channel width.
// RULE14 - Host must avoid 250 and 500 kHz in the 169 MHz band.
// RULE15 - Symbol rate equals bandwidth divided by two to the exponent.
// RULE16 - One bit picks explicit or headerless mode; explicit by default.
// RULE17 - Out-of-range exponent and FEC values are refused, no effect.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spread_modem_param_config #(
  parameter int FIFO_AW = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic spread_mode,
  output logic [2:0] op_mode,
  output logic [3:0] chip_exponent,
  output logic [12:0] chips_per_symbol,
  output logic [2:0] fec_ratio,
  output logic [2:0] overhead_quarters,
  output logic [2:0] header_fec_ratio,
  output logic headerless,
  output logic [spread_cfg_pkg::BW_W-1:0] bandwidth_hz,
  output logic [spread_cfg_pkg::BW_W-1:0] symbol_rate,
  output logic [2:0] detect_tuning,
  output logic [7:0] detect_level
);

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic sel_reg, sel_next;
  logic [2:0] mode_reg, mode_next;
  logic [3:0] exp_reg, exp_next;
  logic [2:0] fec_reg, fec_next;
  logic [3:0] bw_reg, bw_next;
  logic hdrless_reg, hdrless_next;
  logic [2:0] tune_reg, tune_next;
  logic [7:0] level_reg, level_next;
  logic [7:0] fsk_bw_reg, fsk_bw_next;
  logic [FIFO_AW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [12:0] cps_reg, cps_next;
  logic [2:0] ovh_reg, ovh_next;
  logic [2:0] hfec_reg, hfec_next;
  logic [spread_cfg_pkg::BW_W-1:0] bwhz_reg, bwhz_next;
  logic [spread_cfg_pkg::BW_W-1:0] srate_reg, srate_next;

  logic [FIFO_AW:0] count;
  logic empty, full, first_acc, done, mapped;

  buf_port_if #(.AW(FIFO_AW), .DW(8)) bport ();

  // [RULE2]
  buf_mem #(.AW(FIFO_AW), .DW(8)) u_mem (
    .pclk(pclk),
    .ce(ce),
    .port(bport)
  );

  assign count = wptr_reg - rptr_reg;
  assign empty = (count == '0);
  assign full = count[FIFO_AW];
  // One wait state gives the buffer memory time to present read data.
  assign first_acc = psel && penable && !pready_reg;
  assign done = psel && penable && pready_reg;

  // ***************************************************************
  // Address decode: the visible map depends on the modem selected
  // ***************************************************************
  always_comb
  begin
    mapped = 1'b0;
    if (paddr == spread_cfg_pkg::ADDR_OPMODE ||
        paddr == spread_cfg_pkg::ADDR_SETUP_ONE)
    begin
      mapped = 1'b1;
    end
    else if (sel_reg) // [RULE3]
    begin
      mapped = (paddr == spread_cfg_pkg::ADDR_SETUP_TWO) ||
               (paddr == spread_cfg_pkg::ADDR_DETECT_TUNE) ||
               (paddr == spread_cfg_pkg::ADDR_DETECT_LEVEL) ||
               (paddr == spread_cfg_pkg::ADDR_FIFO_DATA) ||
               (paddr == spread_cfg_pkg::ADDR_STATUS);
    end
  end

  // ***************************************************************
  // Bus answer and register writes
  // ***************************************************************
  always_comb
  begin
    logic [3:0] w_exp;
    logic [2:0] w_fec;
    logic [3:0] w_bw;
    logic fifo_rd, fifo_wr;
    w_exp = pwdata[spread_cfg_pkg::EXP_LSB +: 4];
    w_fec = pwdata[spread_cfg_pkg::FEC_LSB +: 3];
    w_bw = pwdata[spread_cfg_pkg::BW_LSB +: 4];
    fifo_rd = sel_reg && paddr == spread_cfg_pkg::ADDR_FIFO_DATA;
    fifo_wr = fifo_rd;
    sel_next = sel_reg;
    mode_next = mode_reg;
    exp_next = exp_reg;
    fec_next = fec_reg;
    bw_next = bw_reg;
    hdrless_next = hdrless_reg;
    tune_next = tune_reg;
    level_next = level_reg;
    fsk_bw_next = fsk_bw_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    prdata_next = prdata_reg;
    pready_next = first_acc;
    pslverr_next = 1'b0;
    bport.wr_en = 1'b0;
    bport.wr_addr = wptr_reg[FIFO_AW-1:0];
    bport.wr_data = pwdata[7:0];
    bport.rd_addr = rptr_reg[FIFO_AW-1:0];
    if (first_acc)
    begin
      prdata_next = 32'h00000000;
      pslverr_next = !mapped ||
                     (fifo_rd && !pwrite && empty) ||
                     (fifo_wr && pwrite && full);
      if (!pwrite)
      begin
        unique case (paddr)
          spread_cfg_pkg::ADDR_OPMODE:
            prdata_next = {24'h000000, sel_reg, 4'h0, mode_reg};
          spread_cfg_pkg::ADDR_SETUP_ONE:
            if (sel_reg)
            begin
              prdata_next = {24'h000000, bw_reg, fec_reg, hdrless_reg};
            end
            else
            begin
              prdata_next = {24'h000000, fsk_bw_reg};
            end
          spread_cfg_pkg::ADDR_SETUP_TWO:
            prdata_next = {24'h000000, exp_reg, 4'h0};
          spread_cfg_pkg::ADDR_DETECT_TUNE:
            prdata_next = {29'h00000000, tune_reg};
          spread_cfg_pkg::ADDR_DETECT_LEVEL:
            prdata_next = {24'h000000, level_reg};
          spread_cfg_pkg::ADDR_FIFO_DATA:
            if (!empty)
            begin
              prdata_next = {24'h000000, bport.rd_data};
            end
          spread_cfg_pkg::ADDR_STATUS:
            prdata_next = {16'h0000, {(8-FIFO_AW-1){1'b0}}, count,
                           6'h00, full, empty};
          default:
            prdata_next = 32'h00000000;
        endcase
        if (!mapped)
        begin
          prdata_next = 32'h00000000;
        end
      end
    end
    if (done && pwrite && mapped)
    begin
      unique case (paddr)
        spread_cfg_pkg::ADDR_OPMODE:
        begin
          mode_next = pwdata[2:0];
          if (mode_reg == spread_cfg_pkg::OPMODE_SLEEP) // [RULE1]
          begin
            sel_next = pwdata[spread_cfg_pkg::MODE_SEL_BIT];
          end
        end
        spread_cfg_pkg::ADDR_SETUP_ONE:
          if (sel_reg)
          begin
            hdrless_next = pwdata[spread_cfg_pkg::HDRLESS_BIT]; // [RULE16]
            if (w_fec >= spread_cfg_pkg::FEC_MIN &&
                w_fec <= spread_cfg_pkg::FEC_MAX) // [RULE17]
            begin
              fec_next = w_fec; // [RULE10]
            end
            if (w_bw <= spread_cfg_pkg::BW_MAX) // [RULE12]
            begin
              bw_next = w_bw;
            end
          end
          else
          begin
            fsk_bw_next = pwdata[7:0];
          end
        spread_cfg_pkg::ADDR_SETUP_TWO:
          if (w_exp >= spread_cfg_pkg::EXP_MIN &&
              w_exp <= spread_cfg_pkg::EXP_MAX) // [RULE17]
          begin
            exp_next = w_exp; // [RULE4]
          end
        spread_cfg_pkg::ADDR_DETECT_TUNE:
          tune_next = pwdata[2:0];
        spread_cfg_pkg::ADDR_DETECT_LEVEL:
          level_next = pwdata[7:0];
        spread_cfg_pkg::ADDR_FIFO_DATA:
          if (!full)
          begin
            bport.wr_en = 1'b1; // [RULE2]
            wptr_next = wptr_reg + 1'b1;
          end
        default:
          mode_next = mode_reg;
      endcase
    end
    if (done && !pwrite && fifo_rd && !empty)
    begin
      rptr_next = rptr_reg + 1'b1;
    end
  end

  // ***************************************************************
  // Derived modem parameters
  // ***************************************************************
  always_comb
  begin
    cps_next = 13'h0001 << exp_reg; // [RULE4]
    ovh_next = 3'(spread_cfg_pkg::FEC_BASE_QUARTERS + fec_reg); // [RULE10]
    hfec_next = hdrless_reg ? 3'h0 : fec_reg; // [RULE11]
    bwhz_next = spread_cfg_pkg::bw_hz(bw_reg); // [RULE13]
    srate_next = bwhz_reg >> exp_reg; // [RULE15]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_reg <= 1'b0;
      mode_reg <= spread_cfg_pkg::OPMODE_RESET;
      exp_reg <= spread_cfg_pkg::EXP_RESET;
      fec_reg <= spread_cfg_pkg::FEC_RESET;
      bw_reg <= spread_cfg_pkg::BW_RESET;
      hdrless_reg <= 1'b0; // [RULE16]
      tune_reg <= spread_cfg_pkg::TUNE_RESET;
      level_reg <= spread_cfg_pkg::LEVEL_RESET;
      fsk_bw_reg <= spread_cfg_pkg::FSK_BW_RESET;
      wptr_reg <= '0;
      rptr_reg <= '0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      cps_reg <= 13'h0080;
      ovh_reg <= 3'h5;
      hfec_reg <= spread_cfg_pkg::FEC_RESET;
      bwhz_reg <= '0;
      srate_reg <= '0;
    end
    else if (ce)
    begin
      sel_reg <= sel_next;
      mode_reg <= mode_next;
      exp_reg <= exp_next;
      fec_reg <= fec_next;
      bw_reg <= bw_next;
      hdrless_reg <= hdrless_next;
      tune_reg <= tune_next;
      level_reg <= level_next;
      fsk_bw_reg <= fsk_bw_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      cps_reg <= cps_next;
      ovh_reg <= ovh_next;
      hfec_reg <= hfec_next;
      bwhz_reg <= bwhz_next;
      srate_reg <= srate_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign spread_mode = sel_reg;
  assign op_mode = mode_reg;
  assign chip_exponent = exp_reg;
  assign chips_per_symbol = cps_reg;
  assign fec_ratio = fec_reg;
  assign overhead_quarters = ovh_reg;
  assign header_fec_ratio = hfec_reg;
  assign headerless = hdrless_reg;
  assign bandwidth_hz = bwhz_reg;
  assign symbol_rate = srate_reg;
  assign detect_tuning = tune_reg;
  assign detect_level = level_reg;

endmodule
`default_nettype wire

/* verif/spread_cfg_props.sv */
// Concurrent checks on the ports of the modem configuration block.
`timescale 1ns/1ps
`default_nettype none
module spread_cfg_props #(
  parameter int FIFO_AW = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic spread_mode,
  input wire logic [2:0] op_mode,
  input wire logic [3:0] chip_exponent,
  input wire logic [12:0] chips_per_symbol,
  input wire logic [2:0] fec_ratio,
  input wire logic [2:0] overhead_quarters,
  input wire logic [2:0] header_fec_ratio,
  input wire logic headerless,
  input wire logic [spread_cfg_pkg::BW_W-1:0] bandwidth_hz,
  input wire logic [spread_cfg_pkg::BW_W-1:0] symbol_rate,
  input wire logic [2:0] detect_tuning,
  input wire logic [7:0] detect_level
);
  // ***************************************************************
  // Sequences
  // ***************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence first_access;
    psel && penable && !pready && ce;
  endsequence
  sequence rate_inputs_quiet;
    ($stable(bandwidth_hz) && $stable(chip_exponent))[*3];
  endsequence
  sequence fsk_done;
    psel && penable && pready && !spread_mode && paddr > 8'h04;
  endsequence
  // ***************************************************************
  // Assertions
  // ***************************************************************
  AST_WAIT_ONE: assert property (first_access |=> pready)
    else $error("no answer in second access cycle");
  AST_READY_PULSE: assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  AST_FSK_MAP: assert property (fsk_done |-> pslverr)
    else $error("spread register visible in FSK map");
  AST_SLEEP_SWAP: assert property ($changed(spread_mode) |-> $past(op_mode) == 3'h0)
    else $error("modem swapped outside Sleep");
  AST_CHIPS: assert property (chips_per_symbol == 13'h0001 << $past(chip_exponent))
    else $error("chips per symbol wrong");
  AST_OVERHEAD: assert property (overhead_quarters == 3'($past(fec_ratio) + 3'h4))
    else $error("overhead does not follow ratio");
  AST_HEADER_FEC: assert property ($stable(fec_ratio) && $stable(headerless)
    |-> header_fec_ratio == (headerless ? 3'h0 : fec_ratio))
    else $error("header ratio wrong");
  AST_SYMBOL_RATE: assert property (rate_inputs_quiet
    |-> symbol_rate == bandwidth_hz >> chip_exponent)
    else $error("symbol rate wrong");
endmodule
bind spread_modem_param_config spread_cfg_props #(.FIFO_AW(FIFO_AW)) chk_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .spread_mode(spread_mode),
  .op_mode(op_mode), .chip_exponent(chip_exponent),
  .chips_per_symbol(chips_per_symbol), .fec_ratio(fec_ratio),
  .overhead_quarters(overhead_quarters), .header_fec_ratio(header_fec_ratio),
  .headerless(headerless), .bandwidth_hz(bandwidth_hz),
  .symbol_rate(symbol_rate), .detect_tuning(detect_tuning),
  .detect_level(detect_level));
`default_nettype wire

/* verif/host_apb.sv */
// Host processor model: APB master and exponent setup sequence.
`timescale 1ns/1ps
`default_nettype none
module host_apb (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rd_q = 32'h0;
  logic err_q = 1'b0;
  logic hung = 1'b0;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // A sticky hang flag lets the bench abort after any chain of transfers.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd_q = prdata;
    err_q = pslverr;
    hung = hung | (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Exponent six needs its own detector settings; others get the defaults.
  task automatic set_exponent(input logic [3:0] e);
    xfer(1'b1, 8'h08, 32'(e) << 4);
    xfer(1'b1, 8'h0C, (e == 4'h6) ? 32'h5 : 32'h3);
    xfer(1'b1, 8'h10, (e == 4'h6) ? 32'h0C : 32'h0A);
  endtask
endmodule
`default_nettype wire

/* verif/spread_modem_param_config_tb_top.sv */
// Self-checking bench for the modem configuration block.
`timescale 1ns/1ps
`default_nettype none
module spread_modem_param_config_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, spread_mode, hdrless;
  logic [7:0] paddr, level;
  logic [31:0] pwdata, prdata;
  logic [2:0] op_mode, fec, ovh, hdr_fec, tune;
  logic [3:0] ex, bw, exp_o;
  logic [2:0] fe;
  logic [12:0] chips;
  logic [18:0] bw_hz, rate;
  logic [18:0] bw_tab [10] = '{19'h01E78, 19'h028A0, 19'h03CF0, 19'h05140,
    19'h079E0, 19'h0A2E4, 19'h0F424, 19'h1E848, 19'h3D090, 19'h7A120};
  int mismatches = 0;
  int compares = 0;
  always #12.5 pclk = ~pclk;
  spread_modem_param_config dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spread_mode(spread_mode), .op_mode(op_mode), .chip_exponent(exp_o),
    .chips_per_symbol(chips), .fec_ratio(fec), .overhead_quarters(ovh),
    .header_fec_ratio(hdr_fec), .headerless(hdrless), .bandwidth_hz(bw_hz),
    .symbol_rate(rate), .detect_tuning(tune), .detect_level(level));
  host_apb host_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(w, a, d);
    if (host_u.hung)
    begin
      mismatches++;
      close_out();
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_map();
    chk(32'(op_mode), 32'h1);
    chk(32'(chips), 32'h80);
    chk(32'(rate), 32'h3D0);
    acc(1'b0, 8'h08, 32'h0);
    chk(32'(host_u.err_q), 32'h1);
    acc(1'b0, 8'h04, 32'h0);
    chk(host_u.rd_q, 32'h15);
    acc(1'b1, 8'h00, 32'h80);
    chk(32'(spread_mode), 32'h0);
    chk(32'(op_mode), 32'h0);
    acc(1'b1, 8'h00, 32'h80);
    chk(32'(spread_mode), 32'h1);
    acc(1'b0, 8'h04, 32'h0);
    chk(host_u.rd_q, 32'h72);
    acc(1'b0, 8'h1C, 32'h0);
    chk({host_u.rd_q[30:0], host_u.err_q}, 32'h1);
  endtask
  task automatic t_exp();
    ex = 4'h7;
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, 8'h08, 32'(i) << 4);
      ex = (i >= 6 && i <= 12) ? 4'(i) : ex;
      chk(32'(exp_o), 32'(ex));
      chk(32'(chips), 32'h1 << ex);
      chk(32'(rate), 32'h1E848 >> ex);
    end
  endtask
  task automatic t_fec_bw();
    bw = 4'h7;
    fe = 3'h1;
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, 8'h04, 32'((i << 4) | ((i % 8) << 1) | (i % 2)));
      bw = (i <= 9) ? 4'(i) : bw;
      fe = (i % 8 >= 1 && i % 8 <= 4) ? 3'(i % 8) : fe;
      chk(32'(bw_hz), 32'(bw_tab[bw]));
      chk(32'({fec, ovh}), 32'({fe, 3'(fe + 3'h4)}));
      chk(32'({hdrless, hdr_fec}), (i % 2) ? 32'h8 : 32'(fe));
    end
  endtask
  task automatic t_detect();
    acc(1'b1, 8'h04, 32'h73);
    host_u.set_exponent(4'h6);
    acc(1'b0, 8'h0C, 32'h0);
    chk(32'({chips, tune, level}), 32'({13'h0040, 3'h5, 8'h0C}));
    host_u.set_exponent(4'h9);
    acc(1'b0, 8'h10, 32'h0);
    chk({host_u.rd_q[23:0], 5'h0, tune}, 32'h0A03);
  endtask
  // A frozen clock enable must stretch the transfer, not lose the write.
  task automatic t_freeze();
    fork
      acc(1'b1, 8'h0C, 32'h6);
      begin
        @(posedge pclk);
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(32'(pready), 32'h0);
        ce <= 1'b1;
      end
    join
    chk(32'(tune), 32'h6);
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 130; i++)
    begin
      acc(i >= 65 ? 1'b0 : 1'b1, 8'h14, 32'(i) ^ 32'hA5);
      chk(32'(host_u.err_q), 32'(i == 64 || i == 129));
      if (i >= 65 && i < 129)
        chk(32'(host_u.rd_q[7:0]), 32'(8'(i - 65) ^ 8'hA5));
      if (i == 64 || i == 129)
      begin
        acc(1'b0, 8'h18, 32'h0);
        chk(host_u.rd_q, i == 64 ? 32'h4002 : 32'h1);
      end
    end
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_map();
    t_exp();
    t_fec_bw();
    t_detect();
    t_freeze();
    t_fifo();
    close_out();
  end
endmodule
`default_nettype wire
